//--- tci_pkg.sv
// Constants and carrier types for the timer channel interrupt mask block.
// Assumes a 32-bit APB slave port and events produced on the same clock.
package tci_pkg;

	localparam int TCI_NUM_SRC = 8;
	localparam int TCI_DATA_W = 32;

	// Event source positions, shared by status, enable, disable and mask.
	localparam int TCI_BIT_OVERFLOW = 0;
	localparam int TCI_BIT_OVERRUN = 1;
	localparam int TCI_BIT_CMP_A = 2;
	localparam int TCI_BIT_CMP_B = 3;
	localparam int TCI_BIT_CMP_C = 4;
	localparam int TCI_BIT_CAP_A = 5;
	localparam int TCI_BIT_CAP_B = 6;
	localparam int TCI_BIT_EXT_TRIG = 7;

	// Extra status positions.
	localparam int TCI_BIT_CLOCK_ON = 16;
	localparam int TCI_BIT_LINE_A = 17;
	localparam int TCI_BIT_LINE_B = 18;

	// Byte addresses of the registers.
	localparam logic [31:0] TCI_ADDR_STATUS = 32'hfffa0020;
	localparam logic [31:0] TCI_ADDR_ENABLE_SET = 32'hfffa0024;
	localparam logic [31:0] TCI_ADDR_ENABLE_CLEAR = 32'hfffa0028;
	localparam logic [31:0] TCI_ADDR_MASK_VIEW = 32'hfffa002c;

	localparam logic [7:0] TCI_MASK_RESET = 8'h00;
	localparam logic [7:0] TCI_STATUS_RESET = 8'h00;
	localparam logic [31:0] TCI_RDATA_RESET = 32'h00000000;

	// Sources that only exist in capture mode, and those only in waveform mode.
	localparam logic [7:0] TCI_CAPTURE_ONLY = 8'h62;
	localparam logic [7:0] TCI_WAVE_ONLY = 8'h0c;

	typedef enum logic [1:0] {
		TCI_IDLE = 2'b00,
		TCI_RESPOND = 2'b01
	} tci_apb_e;

	// One-cycle event pulses, most significant source first.
	typedef struct packed {
		logic ext_trigger_event;
		logic capture_b_event;
		logic capture_a_event;
		logic compare_c_event;
		logic compare_b_event;
		logic compare_a_event;
		logic capture_overrun_event;
		logic overflow_event;
	} tci_evt_s;

	// Levels of the two timer lines, as pin and as driven value.
	typedef struct packed {
		logic timer_line_a;
		logic timer_line_b;
	} tci_line_s;

endpackage

//--- tci_channel_irq.sv
// Interrupt mask, sticky event status and line mirror for one timer channel.
// Assumes events and mode flags come from logic on pclk; line pins are asynchronous.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RULE1 - Status bit 16 shows whether the channel counter clock is enabled.
// RULE2 - Status bit 17 mirrors line A: pin level in capture, driven level in waveform.
// RULE3 - Status bit 18 mirrors line B: pin level in capture, driven level in waveform.
// RULE4 - Enable, disable and mask share one eight-source bit layout, bits 0 to 7.
// RULE5 - Writing 1 to an enable bit sets its mask bit; 0 changes nothing.
// RULE6 - Enable bits for compare A, B and C set their mask bits.
// RULE7 - Enable bits for capture loads A and B set their mask bits.
// RULE8 - Enable bits for external trigger and load overrun set their mask bits.
// RULE9 - Writing 1 to a disable bit clears its mask bit; 0 changes nothing.
// RULE10 - Disabling overrun and capture loads acts in capture mode only.
// RULE11 - Disabling compare A and B acts in waveform mode only.
// RULE12 - Disabling compare C and external trigger acts in both modes.
// RULE13 - The mask register reads 1 for enabled sources, 0 for disabled ones.
// RULE14 - Event status bits set on events and clear when status is read.
// RULE15 - Interrupt is high while any status bit and its mask bit are set; the code counts only sources of the present mode.
module tci_channel_irq #(
	parameter int NUM_SRC = tci_pkg::TCI_NUM_SRC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire tci_pkg::tci_evt_s events,
	input wire logic wave_mode,
	input wire logic clock_on_flag,
	input wire tci_pkg::tci_line_s line_pin,
	input wire tci_pkg::tci_line_s line_drive,
	output logic channel_irq
);

	tci_pkg::tci_apb_e state;
	tci_pkg::tci_apb_e next_state;

	logic [NUM_SRC-1:0] mask;
	logic [NUM_SRC-1:0] status;
	logic [NUM_SRC-1:0] next_mask;
	logic [NUM_SRC-1:0] next_status;
	logic [NUM_SRC-1:0] snap_status;
	logic [NUM_SRC-1:0] event_bits;
	logic [NUM_SRC-1:0] mode_ok;
	logic [NUM_SRC-1:0] set_bits;
	logic [NUM_SRC-1:0] clear_bits;
	logic [NUM_SRC-1:0] read_clear;

	tci_pkg::tci_line_s pin_meta;
	tci_pkg::tci_line_s pin_sync;
	logic line_a_mirror;
	logic line_b_mirror;

	logic setup;
	logic done;
	logic hit_status;
	logic hit_set;
	logic hit_clear;
	logic hit_mask;
	logic mapped;
	logic bad_access;
	logic [31:0] read_word;

	// Bus phase decode.
	assign setup = psel & ~penable;
	assign done = psel & penable & pready;

	assign hit_status = (paddr == tci_pkg::TCI_ADDR_STATUS);
	assign hit_set = (paddr == tci_pkg::TCI_ADDR_ENABLE_SET);
	assign hit_clear = (paddr == tci_pkg::TCI_ADDR_ENABLE_CLEAR);
	assign hit_mask = (paddr == tci_pkg::TCI_ADDR_MASK_VIEW);
	assign mapped = hit_status | hit_set | hit_clear | hit_mask;

	// Writes to read-only registers and any unmapped address answer with an error.
	assign bad_access = ~mapped | (pwrite & (hit_status | hit_mask));

	// The slave answers in the first access cycle after every setup cycle.
	always_comb begin
		next_state = state;
		case (state)
			tci_pkg::TCI_IDLE: begin
				if (setup) begin
					next_state = tci_pkg::TCI_RESPOND;
				end
			end
			tci_pkg::TCI_RESPOND: begin
				if (setup) begin
					next_state = tci_pkg::TCI_RESPOND;
				end else begin
					next_state = tci_pkg::TCI_IDLE;
				end
			end
			default: begin
				next_state = tci_pkg::TCI_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= tci_pkg::TCI_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign pready = (state == tci_pkg::TCI_RESPOND) & psel & penable;

	// Two flip-flops on each line pin before the mirror looks at it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= line_pin;
			pin_sync <= pin_meta;
		end
	end

	// RULE2 line A mirror.
	assign line_a_mirror = wave_mode ? line_drive.timer_line_a : pin_sync.timer_line_a;
	// RULE3 line B mirror.
	assign line_b_mirror = wave_mode ? line_drive.timer_line_b : pin_sync.timer_line_b;

	// Sources that exist in the present mode.
	assign mode_ok = wave_mode ? ~tci_pkg::TCI_CAPTURE_ONLY : ~tci_pkg::TCI_WAVE_ONLY;

	// RULE4 common source layout.
	assign event_bits = events;

	// RULE5 enable register sets.
	assign set_bits = (done & pwrite & hit_set) ? pwdata[NUM_SRC-1:0] : '0;

	// RULE9 disable register clears.
	assign clear_bits = (done & pwrite & hit_clear) ? pwdata[NUM_SRC-1:0] & mode_ok : '0;

	// RULE14 read clears only the bits that were returned.
	assign read_clear = (done & ~pwrite & hit_status) ? snap_status : '0;

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g = g + 1) begin : g_src
			// RULE6 RULE7 RULE8 per source set, clear and hold.
			// RULE10 RULE11 RULE12 mode gated clear.
			always_comb begin
				if (set_bits[g]) begin
					next_mask[g] = 1'b1;
				end else if (clear_bits[g]) begin
					next_mask[g] = 1'b0;
				end else begin
					next_mask[g] = mask[g];
				end
			end

			// RULE14 event set wins over read clear.
			always_comb begin
				if (event_bits[g] & mode_ok[g]) begin
					next_status[g] = 1'b1;
				end else if (read_clear[g]) begin
					next_status[g] = 1'b0;
				end else begin
					next_status[g] = status[g];
				end
			end
		end
	endgenerate

	// RULE15 mask bits reset to zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= tci_pkg::TCI_MASK_RESET;
		end else begin
			mask <= next_mask;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= tci_pkg::TCI_STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	// Status bits of sources of the other mode read as zero; the mask view returns all eight mask bits.
	always_comb begin
		read_word = '0;
		if (hit_status) begin
			read_word[NUM_SRC-1:0] = status & mode_ok;
			// RULE1 clock enabled flag.
			read_word[tci_pkg::TCI_BIT_CLOCK_ON] = clock_on_flag;
			read_word[tci_pkg::TCI_BIT_LINE_A] = line_a_mirror;
			read_word[tci_pkg::TCI_BIT_LINE_B] = line_b_mirror;
		end else if (hit_mask) begin
			// RULE13 mask readback.
			read_word[NUM_SRC-1:0] = mask;
		end
	end

	// Read data and error are captured in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= tci_pkg::TCI_RDATA_RESET;
			pslverr <= 1'b0;
			snap_status <= tci_pkg::TCI_STATUS_RESET;
		end else if (setup) begin
			prdata <= pwrite ? tci_pkg::TCI_RDATA_RESET : read_word;
			pslverr <= bad_access;
			snap_status <= (hit_status & ~pwrite) ? status & mode_ok : '0;
		end
	end

	// RULE15 interrupt level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_irq <= 1'b0;
		end else begin
			channel_irq <= |(next_status & next_mask & mode_ok);
		end
	end

endmodule // tci_channel_irq

`default_nettype wire

//--- tci_channel_irq_sva.sv
// Port checker for the timer channel interrupt mask block.
// Assumes it is bound to the block's top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module tci_channel_irq_sva #(
	parameter int NUM_SRC = tci_pkg::TCI_NUM_SRC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire tci_pkg::tci_evt_s events,
	input wire logic wave_mode,
	input wire logic clock_on_flag,
	input wire tci_pkg::tci_line_s line_pin,
	input wire tci_pkg::tci_line_s line_drive,
	input wire logic channel_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic rd = psel & ~penable & ~pwrite;
	wire logic st = paddr == tci_pkg::TCI_ADDR_STATUS;
	wire logic mv = paddr == tci_pkg::TCI_ADDR_MASK_VIEW;
	wire logic wo = paddr == tci_pkg::TCI_ADDR_ENABLE_SET || paddr == tci_pkg::TCI_ADDR_ENABLE_CLEAR;
	AST_READY: assert property (psel && penable |-> pready)
		else $error("ready missing");
	AST_CLOCK_BIT: assert property (rd && st |=> prdata[16] == $past(clock_on_flag))
		else $error("clock bit wrong");
	AST_LINE_A: assert property (rd && st && wave_mode |=> prdata[17] == $past(line_drive.timer_line_a))
		else $error("line a wrong");
	AST_LINE_B: assert property (rd && st && wave_mode |=> prdata[18] == $past(line_drive.timer_line_b))
		else $error("line b wrong");
	AST_MASK_HIGH: assert property (rd && mv |=> prdata[31:8] == 24'h0)
		else $error("mask high bits set");
	AST_WO_READ: assert property (rd && wo |=> prdata == 32'h0)
		else $error("write-only read nonzero");
	AST_RO_WRITE: assert property (psel && !penable && pwrite && mv |=> pslverr)
		else $error("mask write accepted");
	AST_IRQ_MASKED: assert property (psel && penable && !pwrite && mv && prdata[7:0] == 8'h0 |-> !channel_irq)
		else $error("irq with empty mask");
	COV_IRQ: cover property ($rose(channel_irq));
	COV_ERR: cover property (pready && pslverr);
	COV_STATUS: cover property (rd && st);
endmodule // tci_channel_irq_sva
`default_nettype wire

//--- tci_channel_irq_tb.sv
// Self-checking bench for the timer channel interrupt mask block.
// Assumes the block answers APB on its own; every wait is bounded.
`timescale 1ns/1ns
`default_nettype none
module tci_channel_irq_tb;
	localparam logic [31:0] ST = tci_pkg::TCI_ADDR_STATUS;
	localparam logic [31:0] ES = tci_pkg::TCI_ADDR_ENABLE_SET;
	localparam logic [31:0] EC = tci_pkg::TCI_ADDR_ENABLE_CLEAR;
	localparam logic [31:0] MV = tci_pkg::TCI_ADDR_MASK_VIEW;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic wave_mode = 1'b0, clock_on_flag = 1'b0, pready, pslverr, channel_irq, err;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	tci_pkg::tci_evt_s events = '0;
	tci_pkg::tci_line_s line_pin = '0, line_drive = '0;
	int miscompares = 0, checks = 0;
	tci_channel_irq DUT (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.events(events),
		.wave_mode(wave_mode),
		.clock_on_flag(clock_on_flag),
		.line_pin(line_pin),
		.line_drive(line_drive),
		.channel_irq(channel_irq)
	);
	initial forever #10 pclk = ~pclk;
	task automatic print_verdict;
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		if (pready !== 1'b1) begin
			miscompares++;
			print_verdict();
		end
		@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_reset;
		apb(1'b0, MV, '0);
		chk(rd, '0);
		apb(1'b0, ST, '0);
		chk(rd, '0);
	endtask
	task automatic t_enable;
		apb(1'b1, ES, 32'h05);
		apb(1'b0, MV, '0);
		chk(rd, 32'h05);
		apb(1'b1, ES, 32'hfa);
		apb(1'b1, ES, '0);
		apb(1'b0, MV, '0);
		chk(rd, 32'hff);
	endtask
	task automatic t_disable;
		apb(1'b1, EC, '0);
		apb(1'b0, MV, '0);
		chk(rd, 32'hff);
		apb(1'b1, EC, 32'hff);
		apb(1'b0, MV, '0);
		chk(rd, 32'h0c);
		wave_mode <= 1'b1;
		apb(1'b1, EC, 32'hff);
		apb(1'b0, MV, '0);
		chk(rd, '0);
	endtask
	task automatic t_irq;
		wave_mode <= 1'b0;
		apb(1'b1, ES, 32'h01);
		@(posedge pclk);
		events <= 8'h11;
		@(posedge pclk);
		events <= '0;
		@(negedge pclk);
		chk(channel_irq, 1'b1);
		apb(1'b0, ST, '0);
		chk(rd, 32'h11);
		@(negedge pclk);
		chk(channel_irq, 1'b0);
		apb(1'b0, ST, '0);
		chk(rd, '0);
		@(posedge pclk);
		events <= 8'h10;
		@(posedge pclk);
		events <= '0;
		@(negedge pclk);
		chk(channel_irq, 1'b0);
		apb(1'b0, ST, '0);
		chk(rd, 32'h10);
	endtask
	task automatic t_mirror;
		clock_on_flag <= 1'b1;
		wave_mode <= 1'b1;
		line_drive <= 2'b10;
		line_pin <= 2'b01;
		apb(1'b0, ST, '0);
		chk(rd, 32'h00030000);
		wave_mode <= 1'b0;
		apb(1'b0, ST, '0);
		chk(rd, 32'h00050000);
	endtask
	task automatic t_err;
		apb(1'b1, MV, 32'hff);
		chk(err, 1'b1);
		apb(1'b0, 32'hfffa0040, '0);
		chk(err, 1'b1);
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_enable();
		t_disable();
		t_irq();
		t_mirror();
		t_err();
		print_verdict();
	end
endmodule // tci_channel_irq_tb
bind tci_channel_irq tci_channel_irq_sva #(.NUM_SRC(NUM_SRC)) CHK (.*);
`default_nettype wire
